// [include/adcc_pkg.sv]
package adcc_pkg;

    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RES_W  = 12;
    localparam int CHAN_N = 12;
    localparam int DIV_W  = 7;
    localparam int WAIT_W = 2;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_RES_LO  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RES_HI  = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SRC_CLK = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_REF_GN  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_BANDGAP = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_PIN_LO  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PIN_HI  = 4'h9;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CC_START = 7;
    localparam int CC_BUSY  = 6;
    localparam int CC_EN    = 5;
    localparam int CC_JUST  = 4;
    localparam int SC_SRC   = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR  = 1;

    // ************************************************************
    // Writable masks and reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] MSK_CTRL    = 8'hbf;
    localparam logic [DATA_W-1:0] MSK_SRC_CLK = 8'hf7;
    localparam logic [DATA_W-1:0] MSK_REF_GN  = 8'h9f;
    localparam logic [DATA_W-1:0] MSK_BANDGAP = 8'h01;
    localparam logic [DATA_W-1:0] MSK_IRQ     = 8'h03;
    localparam logic [DATA_W-1:0] MSK_PIN_HI  = 8'h0f;
    localparam logic [DATA_W-1:0] RST_REG     = 8'h00;

    // ************************************************************
    // Approximation sequence constants
    // ************************************************************
    localparam logic [RES_W-1:0]  SAR_MSB     = 12'h800;
    localparam logic [3:0]        SAR_TOP     = 4'hb;
    localparam logic [3:0]        CHAN_LAST   = 4'hb;
    localparam logic [WAIT_W-1:0] SETTLE_LAST = 2'h3;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_TRIAL = 3'b010,
        SEQ_DONE  = 3'b100
    } adcc_seq_type;

    // Internal source one-hot: avdd, avdd/2, avdd/4, vr, vr/2, vr/4, ground
    function automatic logic [6:0] adcc_int_src(input logic [3:0] sel);
        logic [6:0] res;
        res = 7'h00;
        unique case (sel)
            4'h1: res = 7'h01;
            4'h2: res = 7'h02;
            4'h3: res = 7'h04;
            4'h5: res = 7'h08;
            4'h6: res = 7'h10;
            4'h7: res = 7'h20;
            4'h8, 4'h9, 4'ha, 4'hb: res = 7'h40;
            default: res = 7'h00;
        endcase
        return res;
    endfunction

endpackage

// [include/adcc_res_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface adcc_res_if;
    logic                          start;
    logic                          enable;
    logic                          tick;
    logic                          cmp;
    logic                          done;
    logic [adcc_pkg::RES_W-1:0]    result;

    modport ctl (output start, output enable, output tick, output cmp,
                 input done, input result);
    modport seq (input start, input enable, input tick, input cmp,
                 output done, output result);
endinterface
`default_nettype wire

// [logic/adcc_clkdiv.sv]
`timescale 1ns/1ns
`default_nettype none
module adcc_clkdiv (
    // Clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_sys_rst,
    // Control
    input  wire logic [2:0]                 i_code,
    input  wire logic                       i_run,
    // Conversion clock enable
    output var  logic                       o_tick
);
    import adcc_pkg::*;

    logic [DIV_W-1:0] cnt_ff;
    wire  [DIV_W-1:0] div_mask;

    // Division mask: 2**code - 1
    assign div_mask = DIV_W'((8'h01 << i_code) - 8'h01);

    // Free count while a conversion runs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !i_run) begin
            cnt_ff <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            o_tick <= ((cnt_ff & div_mask) == div_mask);
        end
    end
endmodule
`default_nettype wire

// [logic/adcc_conv_seq.sv]
`timescale 1ns/1ns
`default_nettype none
module adcc_conv_seq (
    // Clock and reset
    input  wire logic   i_mclk,
    input  wire logic   i_sys_rst,
    // Control side
    adcc_res_if.seq     sr,
    // Trial code to the analog core
    output var  logic [adcc_pkg::RES_W-1:0] o_dac_code
);
    import adcc_pkg::*;

    adcc_seq_type      state_ff;
    logic [3:0]        bit_ff;
    logic [WAIT_W-1:0] wait_ff;
    logic              done_ff;
    wire               settle_end;
    wire  [RES_W-1:0]  bit_mask;
    wire  [RES_W-1:0]  kept;

    // Trial evaluation per bit
    assign settle_end = sr.tick && (wait_ff == SETTLE_LAST);
    assign bit_mask   = RES_W'(12'h001 << bit_ff);
    assign kept       = sr.cmp ? o_dac_code : (o_dac_code & ~bit_mask);
    assign sr.done    = done_ff;
    assign sr.result  = o_dac_code;

    // Successive approximation, one bit per settle window
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !sr.enable) begin
            state_ff   <= SEQ_IDLE;
            o_dac_code <= '0;
            bit_ff     <= '0;
            wait_ff    <= '0;
            done_ff    <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                SEQ_IDLE: if (sr.start) begin
                    state_ff   <= SEQ_TRIAL;
                    o_dac_code <= SAR_MSB;
                    bit_ff     <= SAR_TOP;
                    wait_ff    <= '0;
                end
                SEQ_TRIAL: if (sr.tick) begin
                    wait_ff <= wait_ff + 1'b1;
                    if (settle_end) begin
                        o_dac_code <= kept | (bit_mask >> 1);
                        if (bit_ff == 4'h0) state_ff <= SEQ_DONE;
                        else bit_ff <= bit_ff - 1'b1;
                    end
                end
                SEQ_DONE: begin
                    done_ff  <= 1'b1;
                    state_ff <= SEQ_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [logic/adcc_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - One analog signal routed to converter
// - Twelve channels plus seven internal signals
// - Internal source disconnects external channel
// - Result held in two read-only bytes
// - Justify bit arranges result bytes
// - Unfilled result bits read zero
// - Disabled converter keeps result unchanged
// - Analog pin loses digital function
// - Analog pin loses pull-high
// - Eight-bit control and busy registers
// - Gain amplifier fields from third register
// - Bandgap enable from bit zero
// - Control register resets zero, fixed layout
// - Start after low-high-low on start bit
// - Busy set on trigger while enabled, cleared on end or disable
// - Channel codes above eleven float
// - Conversion clock is power-of-two division
module adcc_top (
    // Clock and reset
    input  wire logic                          i_mclk,
    input  wire logic                          i_sys_rst,
    // Register port
    input  wire logic [adcc_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [adcc_pkg::DATA_W-1:0]   i_wr_data,
    input  wire logic                          i_wr_en,
    input  wire logic                          i_rd_en,
    output var  logic [adcc_pkg::DATA_W-1:0]   o_rd_data,
    // Interrupt
    output var  logic                          o_irq,
    // Analog core
    input  wire logic                          i_cmp_hi,
    output var  logic [adcc_pkg::RES_W-1:0]    o_dac_code,
    output var  logic                          o_conv_power,
    // Signal routing
    output var  logic [adcc_pkg::CHAN_N-1:0]   o_ext_chan_sel,
    output var  logic [6:0]                    o_int_src_sel,
    // Reference and bandgap
    output var  logic                          o_amp_en,
    output var  logic                          o_amp_in_sel,
    output var  logic [1:0]                    o_ref_sel,
    output var  logic [1:0]                    o_gain_sel,
    output var  logic                          o_bandgap_en,
    // Pin sharing
    input  wire logic [adcc_pkg::CHAN_N-1:0]   i_pull_high_req,
    output var  logic [adcc_pkg::CHAN_N-1:0]   o_pin_analog_sel,
    output var  logic [adcc_pkg::CHAN_N-1:0]   o_pull_high_en
);
    import adcc_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [DATA_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] src_clk_ff;
    logic [DATA_W-1:0] ref_gn_ff;
    logic [DATA_W-1:0] bandgap_ff;
    logic [DATA_W-1:0] irq_st_ff;
    logic [DATA_W-1:0] irq_msk_ff;
    logic [CHAN_N-1:0] pin_sel_ff;
    logic [RES_W-1:0]  result_ff;
    logic              busy_ff;
    logic              start_pulse_ff;
    logic              cmp_s1_ff;
    logic              cmp_s2_ff;
    wire               wr_ctrl;
    wire               trigger;
    wire               accept;
    wire               overrun;
    wire               ext_pick;
    wire  [6:0]        nxt_int_src;
    wire  [CHAN_N-1:0] nxt_ext_chan;
    wire  [DATA_W-1:0] res_lo;
    wire  [DATA_W-1:0] res_hi;
    wire  [DATA_W-1:0] irq_set;
    wire  [DATA_W-1:0] nxt_irq_st;
    logic [DATA_W-1:0] rd_mux;

    adcc_res_if res_if ();

    // ************************************************************
    // Register writes
    // ************************************************************

    // Trigger on falling write of start after it was high
    assign wr_ctrl = i_wr_en && (i_addr == OFS_CTRL);
    assign trigger = wr_ctrl && ctrl_ff[CC_START] && !i_wr_data[CC_START];
    assign accept  = trigger && i_wr_data[CC_EN] && !busy_ff;
    assign overrun = trigger && i_wr_data[CC_EN] && busy_ff;

    // Configuration registers, cleared at reset
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_ff    <= RST_REG;
            src_clk_ff <= RST_REG;
            ref_gn_ff  <= RST_REG;
            bandgap_ff <= RST_REG;
            irq_msk_ff <= RST_REG;
            pin_sel_ff <= '0;
        end else if (i_wr_en) begin
            if (i_addr == OFS_CTRL)    ctrl_ff    <= i_wr_data & MSK_CTRL;
            if (i_addr == OFS_SRC_CLK) src_clk_ff <= i_wr_data & MSK_SRC_CLK;
            if (i_addr == OFS_REF_GN)  ref_gn_ff  <= i_wr_data & MSK_REF_GN;
            if (i_addr == OFS_BANDGAP) bandgap_ff <= i_wr_data & MSK_BANDGAP;
            if (i_addr == OFS_IRQ_MSK) irq_msk_ff <= i_wr_data & MSK_IRQ;
            if (i_addr == OFS_PIN_LO)  pin_sel_ff[7:0] <= i_wr_data;
            if (i_addr == OFS_PIN_HI)  pin_sel_ff[11:8] <= i_wr_data[3:0];
        end
    end

    // ************************************************************
    // Conversion control
    // ************************************************************

    // Comparator pin synchroniser
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
        end else begin
            cmp_s1_ff <= i_cmp_hi;
            cmp_s2_ff <= cmp_s1_ff;
        end
    end

    // Sequencer hookup
    assign res_if.start  = start_pulse_ff;
    assign res_if.enable = ctrl_ff[CC_EN];
    assign res_if.cmp    = cmp_s2_ff;

    adcc_clkdiv u_clkdiv (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_code    (src_clk_ff[2:0]),
        .i_run     (busy_ff),
        .o_tick    (res_if.tick)
    );

    adcc_conv_seq u_seq (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .sr         (res_if.seq),
        .o_dac_code (o_dac_code)
    );

    // Busy, start pulse and result capture
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            busy_ff        <= 1'b0;
            start_pulse_ff <= 1'b0;
            result_ff      <= '0;
        end else begin
            start_pulse_ff <= accept;
            if (accept) busy_ff <= 1'b1;
            else if (res_if.done || !ctrl_ff[CC_EN]) busy_ff <= 1'b0;
            if (res_if.done && ctrl_ff[CC_EN]) result_ff <= res_if.result;
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************

    // Set wins over write-one clear
    assign irq_set    = {6'h00, overrun, res_if.done && ctrl_ff[CC_EN]};
    assign nxt_irq_st = (i_wr_en && (i_addr == OFS_IRQ_ST)) ?
                        ((irq_st_ff & ~i_wr_data) | irq_set) : (irq_st_ff | irq_set);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            irq_st_ff <= RST_REG;
            o_irq     <= 1'b0;
        end else begin
            irq_st_ff <= nxt_irq_st & MSK_IRQ;
            o_irq     <= |(irq_st_ff & irq_msk_ff);
        end
    end

    // ************************************************************
    // Signal routing and pins
    // ************************************************************

    // Source decode: internal pick forces external off
    assign nxt_int_src  = adcc_int_src(src_clk_ff[7:SC_SRC]);
    assign ext_pick     = (nxt_int_src == 7'h00);
    assign nxt_ext_chan = (ext_pick && (ctrl_ff[3:0] <= CHAN_LAST)) ?
                          CHAN_N'(12'h001 << ctrl_ff[3:0]) : '0;

    // Registered analog side outputs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_ext_chan_sel   <= '0;
            o_int_src_sel    <= '0;
            o_conv_power     <= 1'b0;
            o_amp_en         <= 1'b0;
            o_amp_in_sel     <= 1'b0;
            o_ref_sel        <= '0;
            o_gain_sel       <= '0;
            o_bandgap_en     <= 1'b0;
            o_pin_analog_sel <= '0;
            o_pull_high_en   <= '0;
        end else begin
            o_ext_chan_sel   <= nxt_ext_chan;
            o_int_src_sel    <= nxt_int_src;
            o_conv_power     <= ctrl_ff[CC_EN];
            o_amp_en         <= ref_gn_ff[7];
            o_amp_in_sel     <= ref_gn_ff[4];
            o_ref_sel        <= ref_gn_ff[3:2];
            o_gain_sel       <= ref_gn_ff[1:0];
            o_bandgap_en     <= bandgap_ff[0];
            o_pin_analog_sel <= pin_sel_ff;
            o_pull_high_en   <= i_pull_high_req & ~pin_sel_ff;
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************

    // Justified result bytes, unused bits zero
    assign res_lo = ctrl_ff[CC_JUST] ? result_ff[7:0] : {result_ff[3:0], 4'h0};
    assign res_hi = ctrl_ff[CC_JUST] ? {4'h0, result_ff[11:8]} : result_ff[11:4];

    always_comb begin
        unique case (i_addr)
            OFS_RES_LO:  rd_mux = res_lo;
            OFS_RES_HI:  rd_mux = res_hi;
            OFS_CTRL:    rd_mux = ctrl_ff | {1'b0, busy_ff, 6'h00};
            OFS_SRC_CLK: rd_mux = src_clk_ff;
            OFS_REF_GN:  rd_mux = ref_gn_ff;
            OFS_BANDGAP: rd_mux = bandgap_ff;
            OFS_IRQ_ST:  rd_mux = irq_st_ff;
            OFS_IRQ_MSK: rd_mux = irq_msk_ff;
            OFS_PIN_LO:  rd_mux = pin_sel_ff[7:0];
            OFS_PIN_HI:  rd_mux = {4'h0, pin_sel_ff[11:8]};
            default:     rd_mux = 8'h00;
        endcase
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) o_rd_data <= 8'h00;
        else o_rd_data <= i_rd_en ? rd_mux : 8'h00;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    busy_set_a: assert property (accept |=> busy_ff && start_pulse_ff)
        else $error("busy not set after trigger");
    busy_clr_a: assert property (res_if.done && !accept |=> !busy_ff)
        else $error("busy not cleared at end");
    res_upd_a: assert property (res_if.done && ctrl_ff[CC_EN]
        |=> result_ff == $past(res_if.result))
        else $error("result not captured at end");
    res_hold_a: assert property (!ctrl_ff[CC_EN] |=> $stable(result_ff))
        else $error("result changed while disabled");
    ext_off_a: assert property (nxt_int_src != 7'h00 |=> o_ext_chan_sel == '0)
        else $error("external channel left on");
    chan_float_a: assert property (ctrl_ff[3:0] > CHAN_LAST |=> o_ext_chan_sel == '0)
        else $error("undefined channel selected");
    one_src_a: assert property ($onehot0({o_ext_chan_sel, o_int_src_sel}))
        else $error("more than one source routed");
    pull_off_a: assert property ((o_pin_analog_sel & o_pull_high_en) == '0)
        else $error("pull-high on analog pin");
    hi_zero_a: assert property (i_rd_en && i_addr == OFS_RES_HI && ctrl_ff[CC_JUST]
        |=> o_rd_data[7:4] == 4'h0)
        else $error("unused result bits not zero");
    rise_only_a: assert property (wr_ctrl && !ctrl_ff[CC_START] |=> !start_pulse_ff)
        else $error("start without falling edge");
    conv_len_a: assert property (start_pulse_ff && src_clk_ff[2:0] == 3'h0
        && $stable(ctrl_ff[CC_EN]) |-> ##[48:60] res_if.done)
        else $error("undivided conversion length wrong");

    // Register map and read path
    ctrl_rst_a: assert property ($fell(i_sys_rst) |-> ctrl_ff == RST_REG)
        else $error("control register not cleared by reset");
    res_ro_a: assert property (i_wr_en && !res_if.done |=> $stable(result_ff))
        else $error("result changed by a bus write");
    lo_zero_a: assert property (i_rd_en && i_addr == OFS_RES_LO && !ctrl_ff[CC_JUST]
        |=> o_rd_data[3:0] == 4'h0)
        else $error("unused low result bits not zero");
    busy_rd_a: assert property (i_rd_en && i_addr == OFS_CTRL
        |=> o_rd_data[CC_BUSY] == $past(busy_ff))
        else $error("busy flag read wrong");

    // Analog side outputs follow their registers
    bg_follow_a: assert property (o_bandgap_en == $past(bandgap_ff[0]))
        else $error("bandgap enable does not follow register");
    pin_dig_a: assert property (o_pin_analog_sel == $past(pin_sel_ff))
        else $error("analog pin selection does not follow register");
    amp_cfg_a: assert property (o_gain_sel == $past(ref_gn_ff[1:0]))
        else $error("gain select does not follow register");

    conv_end_c: cover property (start_pulse_ff ##[1:200] res_if.done);
    overrun_c: cover property (overrun);
    irq_c: cover property (o_irq && irq_st_ff[IRQ_DONE]);
    just_rd_c: cover property (i_rd_en && i_addr == OFS_RES_LO && ctrl_ff[CC_JUST]);
    off_trig_c: cover property (trigger && !i_wr_data[CC_EN]);
endmodule
`default_nettype wire

// [dv/adcc_analog_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Analog core stand-in: comparator against a set input level
// ************************************************************
module adcc_analog_model (
    // Trial code and input level
    input  wire logic [adcc_pkg::RES_W-1:0] i_dac_code,
    input  wire logic [adcc_pkg::RES_W-1:0] i_level,
    // Comparator
    output var  logic                       o_cmp_hi
);
    import adcc_pkg::*;

    // High while the input reaches the trial code
    always_comb begin
        o_cmp_hi = (i_level >= i_dac_code);
    end
endmodule
`default_nettype wire

// [dv/adc_control_and_result_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_control_and_result_bench;
    import adcc_pkg::*;

    logic              i_mclk;
    logic              i_sys_rst;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wr_data;
    logic              i_wr_en;
    logic              i_rd_en;
    logic [DATA_W-1:0] o_rd_data;
    logic              o_irq;
    logic              cmp_hi;
    logic [RES_W-1:0]  o_dac_code;
    logic              o_conv_power;
    logic [CHAN_N-1:0] o_ext_chan_sel;
    logic [6:0]        o_int_src_sel;
    logic              o_amp_en;
    logic              o_amp_in_sel;
    logic [1:0]        o_ref_sel;
    logic [1:0]        o_gain_sel;
    logic              o_bandgap_en;
    logic [CHAN_N-1:0] o_pin_analog_sel;
    logic [CHAN_N-1:0] o_pull_high_en;
    logic [RES_W-1:0]  level;
    logic [CHAN_N-1:0] pull_req;
    logic [7:0]        rd_v;
    int                err_total;
    int                n_tests;
    int                t0;
    int                t1;
    logic [3:0]        src_code [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h4};
    logic [6:0]        src_exp  [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};

    adcc_top dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_irq(o_irq),
        .i_cmp_hi(cmp_hi), .o_dac_code(o_dac_code), .o_conv_power(o_conv_power),
        .o_ext_chan_sel(o_ext_chan_sel), .o_int_src_sel(o_int_src_sel),
        .o_amp_en(o_amp_en), .o_amp_in_sel(o_amp_in_sel), .o_ref_sel(o_ref_sel),
        .o_gain_sel(o_gain_sel), .o_bandgap_en(o_bandgap_en),
        .i_pull_high_req(pull_req), .o_pin_analog_sel(o_pin_analog_sel),
        .o_pull_high_en(o_pull_high_en)
    );

    adcc_analog_model model (
        .i_dac_code(o_dac_code),
        .i_level(level),
        .o_cmp_hi(cmp_hi)
    );

    // ************************************************************
    // Clock and shared tasks
    // ************************************************************
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr    <= a;
        i_wr_data <= d;
        i_wr_en   <= 1'b1;
        @(posedge i_mclk);
        i_wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_addr  <= a;
        i_rd_en <= 1'b1;
        @(posedge i_mclk);
        i_rd_en <= 1'b0;
        #1;
        rd_v = o_rd_data;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, {4'h0, rd_v}, {4'h0, exp});
    endtask

    // Let registered outputs follow the last write
    task automatic settle();
        repeat (2) @(posedge i_mclk);
        #1;
    endtask

    // Trigger by start high then low, poll busy with a bound
    task automatic conv(input logic [7:0] ctl, output int cyc);
        wr(OFS_CTRL, ctl | 8'h80);
        wr(OFS_CTRL, ctl);
        rd(OFS_CTRL);
        chk("busy set", {11'h0, rd_v[CC_BUSY]}, 12'h001);
        cyc = 0;
        while (rd_v[CC_BUSY] !== 1'b0 && cyc < 4000) begin
            rd(OFS_CTRL);
            cyc += 2;
        end
        if (cyc >= 4000) begin
            err_total++;
            give_verdict();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        err_total = 0;
        n_tests   = 0;
        i_sys_rst = 1'b1;
        i_addr    = 4'h0;
        i_wr_data = 8'h00;
        i_wr_en   = 1'b0;
        i_rd_en   = 1'b0;
        level     = 12'habc;
        pull_req  = 12'ha5f;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rchk(OFS_CTRL, 8'h00, "ctrl reset");
        rchk(4'hf, 8'h00, "unmapped");
        wr(OFS_CTRL, 8'h2c);
        settle();
        chk("float chan", o_ext_chan_sel, 12'h000);
        chk("pull idle", o_pull_high_en, 12'ha5f);
        wr(OFS_CTRL, 8'h2b);
        settle();
        chk("chan 11", o_ext_chan_sel, 12'h800);
        $display("test reset and channel done");
        // Conversion and both justifications
        conv(8'h23, t0);
        chk("power on", {11'h0, o_conv_power}, 12'h001);
        rchk(OFS_RES_HI, 8'hab, "hi j0");
        rchk(OFS_RES_LO, 8'hc0, "lo j0");
        wr(OFS_CTRL, 8'h33);
        rchk(OFS_RES_HI, 8'h0a, "hi j1");
        rchk(OFS_RES_LO, 8'hbc, "lo j1");
        wr(OFS_RES_LO, 8'h55);
        rchk(OFS_RES_LO, 8'hbc, "lo ro");
        // Disabled converter keeps result
        level = 12'h123;
        wr(OFS_CTRL, 8'h93);
        wr(OFS_CTRL, 8'h13);
        settle();
        chk("power off", {11'h0, o_conv_power}, 12'h000);
        rchk(OFS_CTRL, 8'h13, "no busy");
        rchk(OFS_RES_LO, 8'hbc, "kept");
        $display("test conversion done");
        // Interrupt raise, mask, clear, overrun
        wr(OFS_IRQ_MSK, 8'h01);
        conv(8'h33, t0);
        settle();
        chk("irq up", {11'h0, o_irq}, 12'h001);
        rchk(OFS_RES_LO, 8'h23, "lo new");
        wr(OFS_IRQ_MSK, 8'h00);
        settle();
        chk("irq masked", {11'h0, o_irq}, 12'h000);
        wr(OFS_IRQ_ST, 8'h01);
        rchk(OFS_IRQ_ST, 8'h00, "irq clear");
        wr(OFS_CTRL, 8'hb3);
        wr(OFS_CTRL, 8'h33);
        wr(OFS_CTRL, 8'hb3);
        wr(OFS_CTRL, 8'h33);
        conv(8'h33, t1);
        rchk(OFS_IRQ_ST, 8'h03, "overrun");
        $display("test interrupt done");
        // Divide by four stretches the conversion
        wr(OFS_SRC_CLK, 8'h02);
        conv(8'h33, t1);
        chk("divide", {11'h0, t1 > 3 * t0}, 12'h001);
        // Internal sources cut the external channel
        for (int k = 0; k < 8; k++) begin
            wr(OFS_SRC_CLK, {src_code[k], 4'h0});
            settle();
            chk("int src", {5'h0, o_int_src_sel}, {5'h0, src_exp[k]});
            chk("ext off", o_ext_chan_sel, (k == 7) ? 12'h008 : 12'h000);
        end
        wr(OFS_SRC_CLK, 8'hff);
        rchk(OFS_SRC_CLK, 8'hf7, "src reg");
        $display("test sources done");
        // Reference, bandgap and pin sharing
        wr(OFS_REF_GN, 8'hff);
        settle();
        chk("amp", {6'h0, o_amp_en, o_amp_in_sel, o_ref_sel, o_gain_sel}, 12'h03f);
        rchk(OFS_REF_GN, 8'h9f, "ref reg");
        wr(OFS_BANDGAP, 8'hff);
        settle();
        chk("bandgap", {11'h0, o_bandgap_en}, 12'h001);
        rchk(OFS_BANDGAP, 8'h01, "bg reg");
        wr(OFS_PIN_LO, 8'h0f);
        settle();
        chk("pin analog", o_pin_analog_sel, 12'h00f);
        chk("pull high", o_pull_high_en, 12'ha50);
        $display("test reference and pins done");
        give_verdict();
    end
endmodule
`default_nettype wire
